// >>> reset_clock_cfg.svh
// Constants for the reset sequencer and PLL clock control block.
// Assumes a 100 MHz ref_clk; included by bare name from design files.
`ifndef RESET_CLOCK_CFG_SVH
`define RESET_CLOCK_CFG_SVH

// ==========================================================
// Register offsets and fields
`define DEV_CTRL_ADDR 8'h00
`define PLL_CTRL_ADDR 8'h01
`define SOFT_RESET_BIT 7
`define PLL_ENABLE_BIT 0
`define PLL_LOCK_BIT 7
`define PLL_SOURCE_BIT 4
`define RATIO_MSB 2
`define RATIO_LSB 0
`define RATIO_MAX_CODE 3'h4

// ==========================================================
// Reset values
`define PLL_ENABLE_DEFAULT 1'b0
`define PLL_SOURCE_DEFAULT 1'b0
`define PLL_RATIO_DEFAULT 3'h1

// ==========================================================
// Timing
`define CLK_PERIOD_NS 10
`define SOFT_RESET_NS 40
`define SOFT_RESET_CYCLES \
   ((`SOFT_RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SOFT_CNT_W 3
`define REF_STALL_NS 40000
`define REF_STALL_CYCLES (`REF_STALL_NS / `CLK_PERIOD_NS)
`define STALL_CNT_W 12
`define PLL_LOCK_EDGES 16
`define LOCK_CNT_W 5

`endif

// >>> reset_clock_pkg.sv
// Types shared by the reset sequencer and PLL clock control block.
// Assumes nothing of its surroundings.
`default_nettype none
package reset_clock_pkg;
   // Gray codes along held -> wait -> run -> discharge
   typedef enum logic [2:0] {
      SEQ_HELD = 3'h0,
      SEQ_WAIT_POR = 3'h1,
      SEQ_RUN = 3'h3,
      SEQ_DISCHARGE = 3'h2,
      SEQ_SOFT = 3'h7
   } seq_state_t;

   typedef enum logic {
      SRC_MCLK = 1'b0,
      SRC_FRAME = 1'b1
   } ref_source_t;
endpackage
`default_nettype wire

// >>> pll_link_if.sv
// Link between the control registers and the PLL lock detector.
// Assumes both ends run on ref_clk.
`timescale 1ns/100ps
`default_nettype none
interface pll_link_if;
   import reset_clock_pkg::*;
   logic enable;
   ref_source_t source;
   logic [2:0] ratio;
   logic mclk_level;
   logic frame_level;
   logic locked;

   modport ctrl (output enable, source, ratio, mclk_level, frame_level,
      input locked);
   modport det (input enable, source, ratio, mclk_level, frame_level,
      output locked);
endinterface
`default_nettype wire

// >>> pin_sync.sv
// Two-flop synchroniser bank for pins from outside the clock domain.
// Assumes a synchronous active-high reset on ref_clk.
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
   parameter int WIDTH = 5
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1;

   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         always_ff @(posedge ref_clk) begin
            if (reset) begin
               stage1[i] <= 1'b0;
               sync_out[i] <= 1'b0;
            end else begin
               stage1[i] <= async_in[i];
               sync_out[i] <= stage1[i];
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

// >>> pll_lock_detect.sv
// Lock detector: counts edges of the selected PLL reference.
// Assumes synchronised reference levels and a reset that covers core reset.
`timescale 1ns/100ps
`default_nettype none
`include "reset_clock_cfg.svh"
module pll_lock_detect (
   input wire logic ref_clk,
   input wire logic reset,
   pll_link_if.det link
);
   import reset_clock_pkg::*;

   logic prev_ref;
   logic [3:0] prev_cfg;
   logic [`LOCK_CNT_W-1:0] edge_cnt;
   logic [`STALL_CNT_W-1:0] stall_cnt;
   logic locked;
   logic next_prev_ref;
   logic [3:0] next_prev_cfg;
   logic [`LOCK_CNT_W-1:0] next_edge_cnt;
   logic [`STALL_CNT_W-1:0] next_stall_cnt;
   logic next_locked;
   logic ref_level;
   logic cfg_ok;

   assign link.locked = locked;

   // ==========================================================
   // Next-state logic
   always_comb begin
      ref_level = (link.source == SRC_FRAME) ? link.frame_level
         : link.mclk_level;
      cfg_ok = (link.source == SRC_FRAME)
         || (link.ratio <= `RATIO_MAX_CODE);
      next_prev_ref = ref_level;
      next_prev_cfg = {link.source, link.ratio};
      next_edge_cnt = edge_cnt;
      next_stall_cnt = stall_cnt;
      next_locked = locked;
      if (!link.enable || !cfg_ok || prev_cfg != next_prev_cfg) begin
         next_edge_cnt = '0;
         next_stall_cnt = '0;
         next_locked = 1'b0;
      end else if (ref_level && !prev_ref) begin
         next_stall_cnt = '0;
         if (edge_cnt != `LOCK_CNT_W'(`PLL_LOCK_EDGES))
            next_edge_cnt = edge_cnt + 1'b1;
         next_locked = (next_edge_cnt == `LOCK_CNT_W'(`PLL_LOCK_EDGES));
      end else if (stall_cnt ==
                   `STALL_CNT_W'(`REF_STALL_CYCLES - 1)) begin
         // Timeout above one 32 kHz frame period
         next_stall_cnt = '0;
         next_edge_cnt = '0;
         next_locked = 1'b0;
      end else begin
         next_stall_cnt = stall_cnt + 1'b1;
      end
   end

   // ==========================================================
   // State registers
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         prev_ref <= 1'b0;
         prev_cfg <= 4'h0;
         edge_cnt <= '0;
         stall_cnt <= '0;
         locked <= 1'b0;
      end else begin
         prev_ref <= next_prev_ref;
         prev_cfg <= next_prev_cfg;
         edge_cnt <= next_edge_cnt;
         stall_cnt <= next_stall_cnt;
         locked <= next_locked;
      end
   end
endmodule
`default_nettype wire

// >>> reset_clock_control.sv
// Reset sequencer and PLL clock control for a four-channel converter.
// Assumes a 100 MHz ref_clk, comparator levels for the core supply
// and a simple register port behind the control-port decoder.
//
// Contract
// - reset pin is active low
// - analog reference off while in reset
// - core regulator off in reset, on after release
// - core held until supply reaches 1.2 V
// - power-on reset hysteresis, 1.2 V and 0.6 V
// - bit 7 of register 0x00 resets device
// - bit 4 of 0x01 selects PLL reference
// - frame clock reference covers 32 to 192 kHz
// - ratio field bits 2:0, codes 0 to 4
// - bit 7 of 0x01 reports PLL lock
// - frame clock reference needs slave serial port
`timescale 1ns/100ps
`default_nettype none
`include "reset_clock_cfg.svh"
module reset_clock_control (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic powerdown_reset_n,
   input wire logic supply_release_ok,
   input wire logic supply_trip_ok,
   input wire logic master_clock_pin,
   input wire logic frame_clock,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   output logic [7:0] reg_rdata,
   output logic regulator_enable,
   output logic reference_enable,
   output logic core_reset_out,
   output logic pll_enable_out,
   output reset_clock_pkg::ref_source_t pll_source_out,
   output logic [2:0] pll_ratio_out
);
   import reset_clock_pkg::*;

   logic pin_s;
   logic release_s;
   logic trip_s;
   logic mclk_s;
   logic frame_s;
   seq_state_t state;
   seq_state_t next_state;
   logic [`SOFT_CNT_W-1:0] soft_cnt;
   logic [`SOFT_CNT_W-1:0] next_soft_cnt;
   logic next_regulator;
   logic next_reference;
   logic next_core_reset;
   logic next_pll_enable;
   ref_source_t next_pll_source;
   logic [2:0] next_pll_ratio;
   logic [7:0] next_rdata;
   logic wr_ok;
   logic soft_req;

   pll_link_if link ();

   // ==========================================================
   // Pin synchronisers
   pin_sync #(.WIDTH(5)) u_sync (
      .ref_clk(ref_clk),
      .reset(reset),
      .async_in({powerdown_reset_n, supply_release_ok, supply_trip_ok,
         master_clock_pin, frame_clock}),
      .sync_out({pin_s, release_s, trip_s, mclk_s, frame_s})
   );

   assign link.enable = pll_enable_out;
   assign link.source = pll_source_out;
   assign link.ratio = pll_ratio_out;
   assign link.mclk_level = mclk_s;
   assign link.frame_level = frame_s;

   // Detector is held while the core is in reset
   pll_lock_detect u_lock (
      .ref_clk(ref_clk),
      .reset(reset || core_reset_out),
      .link(link)
   );

   // ==========================================================
   // Power and reset sequencing
   always_comb begin
      next_state = state;
      next_soft_cnt = soft_cnt;
      soft_req = reg_write && reg_addr == `DEV_CTRL_ADDR
         && reg_wdata[`SOFT_RESET_BIT];
      case (state)
         SEQ_HELD: begin
            if (pin_s)
               next_state = SEQ_WAIT_POR;
         end
         SEQ_WAIT_POR: begin
            if (!pin_s)
               next_state = SEQ_HELD;
            else if (release_s)
               next_state = SEQ_RUN;
         end
         SEQ_RUN: begin
            if (!pin_s) begin
               next_state = SEQ_DISCHARGE;
            end else if (!trip_s) begin
               next_state = SEQ_HELD;
            end else if (soft_req) begin
               next_state = SEQ_SOFT;
               next_soft_cnt = `SOFT_CNT_W'(`SOFT_RESET_CYCLES - 1);
            end
         end
         SEQ_DISCHARGE: begin
            // Core keeps running until supply drops below the low trip
            if (!trip_s)
               next_state = SEQ_HELD;
            else if (pin_s)
               next_state = SEQ_RUN;
         end
         SEQ_SOFT: begin
            if (!pin_s)
               next_state = SEQ_HELD;
            else if (soft_cnt == '0)
               next_state = SEQ_RUN;
            else
               next_soft_cnt = soft_cnt - 1'b1;
         end
         default: begin
            next_state = SEQ_HELD;
         end
      endcase
      next_regulator = (next_state == SEQ_WAIT_POR)
         || (next_state == SEQ_RUN) || (next_state == SEQ_SOFT);
      next_reference = next_regulator;
      next_core_reset = (next_state != SEQ_RUN)
         && (next_state != SEQ_DISCHARGE);
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         state <= SEQ_HELD;
         soft_cnt <= '0;
         regulator_enable <= 1'b0;
         reference_enable <= 1'b0;
         core_reset_out <= 1'b1;
      end else begin
         state <= next_state;
         soft_cnt <= next_soft_cnt;
         regulator_enable <= next_regulator;
         reference_enable <= next_reference;
         core_reset_out <= next_core_reset;
      end
   end

   // ==========================================================
   // Control registers
   always_comb begin
      wr_ok = reg_write && !core_reset_out;
      next_pll_enable = pll_enable_out;
      next_pll_source = pll_source_out;
      next_pll_ratio = pll_ratio_out;
      if (next_core_reset) begin
         next_pll_enable = `PLL_ENABLE_DEFAULT;
         next_pll_source = ref_source_t'(`PLL_SOURCE_DEFAULT);
         next_pll_ratio = `PLL_RATIO_DEFAULT;
      end else if (wr_ok && reg_addr == `DEV_CTRL_ADDR) begin
         next_pll_enable = reg_wdata[`PLL_ENABLE_BIT];
      end else if (wr_ok && reg_addr == `PLL_CTRL_ADDR) begin
         next_pll_source = ref_source_t'(reg_wdata[`PLL_SOURCE_BIT]);
         next_pll_ratio = reg_wdata[`RATIO_MSB:`RATIO_LSB];
      end
      next_rdata = 8'h00;
      if (reg_addr == `DEV_CTRL_ADDR) begin
         next_rdata[`PLL_ENABLE_BIT] = pll_enable_out;
      end else if (reg_addr == `PLL_CTRL_ADDR) begin
         // Lock flag comes from the detector, masked by pll_enable_out
         next_rdata[`PLL_LOCK_BIT] = link.locked && pll_enable_out;
         next_rdata[`PLL_SOURCE_BIT] = pll_source_out;
         next_rdata[`RATIO_MSB:`RATIO_LSB] = pll_ratio_out;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         pll_enable_out <= `PLL_ENABLE_DEFAULT;
         pll_source_out <= SRC_MCLK;
         pll_ratio_out <= `PLL_RATIO_DEFAULT;
         reg_rdata <= 8'h00;
      end else begin
         pll_enable_out <= next_pll_enable;
         pll_source_out <= next_pll_source;
         pll_ratio_out <= next_pll_ratio;
         reg_rdata <= next_rdata;
      end
   end

   // ==========================================================
   // Assertions
   sequence soft_write_s;
      state == SEQ_RUN && pin_s && trip_s && reg_write
         && reg_addr == `DEV_CTRL_ADDR && reg_wdata[`SOFT_RESET_BIT];
   endsequence

   sequence soft_pulse_s;
      core_reset_out [*4] ##1 !core_reset_out;
   endsequence

   sequence pin_drop_s;
      state == SEQ_RUN && !pin_s;
   endsequence

   AST_REF_OFF_HELD: assert property (
      @(posedge ref_clk) disable iff (reset)
      state == SEQ_HELD |-> !reference_enable && !regulator_enable)
      else $error("reference or regulator on while held");

   AST_REG_ON_RELEASE: assert property (
      @(posedge ref_clk) disable iff (reset)
      state == SEQ_HELD && pin_s |=> regulator_enable && reference_enable)
      else $error("regulator not enabled after pin release");

   AST_CORE_WAITS_POR: assert property (
      @(posedge ref_clk) disable iff (reset)
      state == SEQ_WAIT_POR && !release_s |=> core_reset_out)
      else $error("core left reset before supply release level");

   AST_HYST_HOLD: assert property (
      @(posedge ref_clk) disable iff (reset)
      state == SEQ_DISCHARGE && trip_s |=> !core_reset_out)
      else $error("core reset above low trip point");

   AST_HYST_TRIP: assert property (
      @(posedge ref_clk) disable iff (reset)
      state == SEQ_DISCHARGE && !trip_s |=> core_reset_out ##1
         state == SEQ_HELD || pin_s)
      else $error("core not reset below low trip point");

   AST_SOFT_RESET: assert property (
      @(posedge ref_clk) disable iff (reset)
      soft_write_s ##1 pin_s [*4] |-> $past(core_reset_out, 3))
      else $error("software reset pulse missing");

   AST_SOFT_PULSE: assert property (
      @(posedge ref_clk) disable iff (reset || !pin_s || !trip_s)
      soft_write_s |=> soft_pulse_s)
      else $error("software reset pulse length wrong");

   AST_SOFT_DEFAULTS: assert property (
      @(posedge ref_clk) disable iff (reset)
      soft_write_s |=> !pll_enable_out
         && pll_ratio_out == `PLL_RATIO_DEFAULT
         && pll_source_out == SRC_MCLK)
      else $error("registers not at defaults after software reset");

   AST_SOURCE_WRITE: assert property (
      @(posedge ref_clk) disable iff (reset)
      wr_ok && !next_core_reset && reg_addr == `PLL_CTRL_ADDR
      |=> pll_source_out == $past(reg_wdata[`PLL_SOURCE_BIT]))
      else $error("reference select not taken");

   AST_BAD_RATIO: assert property (
      @(posedge ref_clk) disable iff (reset)
      pll_source_out == SRC_MCLK && pll_ratio_out > `RATIO_MAX_CODE
      |=> !link.locked)
      else $error("lock with invalid ratio code");

   AST_LOCK_READ: assert property (
      @(posedge ref_clk) disable iff (reset)
      reg_addr == `PLL_CTRL_ADDR && link.locked && pll_enable_out
      |=> reg_rdata[`PLL_LOCK_BIT])
      else $error("lock flag not reported");

   AST_LOCK_ZERO: assert property (
      @(posedge ref_clk) disable iff (reset)
      reg_addr == `PLL_CTRL_ADDR && (!pll_enable_out || core_reset_out)
      |=> !reg_rdata[`PLL_LOCK_BIT])
      else $error("lock flag set while PLL off or in reset");

   AST_PIN_DROP: assert property (
      @(posedge ref_clk) disable iff (reset)
      pin_drop_s |=> state == SEQ_DISCHARGE && !regulator_enable
         && !reference_enable)
      else $error("pin low did not power down the supplies");

   AST_LOCK_DISABLED: assert property (
      @(posedge ref_clk) disable iff (reset)
      !pll_enable_out |=> !link.locked)
      else $error("detector locked while PLL disabled");

   AST_WRITE_IN_RESET: assert property (
      @(posedge ref_clk) disable iff (reset)
      core_reset_out && reg_write |=> !pll_enable_out
         && pll_ratio_out == `PLL_RATIO_DEFAULT
         && pll_source_out == SRC_MCLK)
      else $error("register write taken while core in reset");
endmodule
`default_nettype wire

// >>> far_side_model.sv
// Far side of the block: system clocks and the core supply comparators.
// Assumes ref_clk at 100 MHz; the run inputs come from the testbench.
`timescale 1ns/100ps
`default_nettype none
module far_side_model (
   input wire logic ref_clk,
   input wire logic powerdown_reset_n,
   input wire logic mclk_run,
   input wire logic frame_run,
   output logic supply_release_ok,
   output logic supply_trip_ok,
   output var logic master_clock_pin,
   output var logic frame_clock
);
   int lvl = 0;

   // ==========================================================
   // Core supply: charges while the pin is high, bleeds when low
   always @(negedge ref_clk) begin
      if (powerdown_reset_n && lvl < 60)
         lvl <= lvl + 1;
      else if (!powerdown_reset_n && lvl > 0)
         lvl <= lvl - 1;
   end
   assign supply_release_ok = (lvl >= 40);
   assign supply_trip_ok = (lvl >= 20);

   // ==========================================================
   // Reference clocks stand still low while their source is idle
   initial begin
      master_clock_pin = 1'b0;
      frame_clock = 1'b0;
   end
   always #40 master_clock_pin = mclk_run ? ~master_clock_pin : 1'b0;
   // Frame clock from an external serial master
   always #60 frame_clock = frame_run ? ~frame_clock : 1'b0;
endmodule
`default_nettype wire

// >>> testbench.sv
// Self-checking bench for the reset sequencer and PLL clock control.
// Assumes the package, interface and design files are compiled first.
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import reset_clock_pkg::*;
   logic ref_clk, reset, powerdown_reset_n, mclk_run, frame_run;
   logic supply_release_ok, supply_trip_ok, master_clock_pin;
   logic frame_clock, reg_write, regulator_enable, reference_enable;
   logic core_reset_out, pll_enable_out;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
   ref_source_t pll_source_out;
   logic [2:0] pll_ratio_out;
   int n_mismatch = 0;
   int checks = 0;

   reset_clock_control dut_u (.ref_clk(ref_clk), .reset(reset),
      .powerdown_reset_n(powerdown_reset_n),
      .supply_release_ok(supply_release_ok),
      .supply_trip_ok(supply_trip_ok),
      .master_clock_pin(master_clock_pin), .frame_clock(frame_clock),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_rdata(reg_rdata), .regulator_enable(regulator_enable),
      .reference_enable(reference_enable),
      .core_reset_out(core_reset_out), .pll_enable_out(pll_enable_out),
      .pll_source_out(pll_source_out), .pll_ratio_out(pll_ratio_out));

   far_side_model model_u (.ref_clk(ref_clk),
      .powerdown_reset_n(powerdown_reset_n), .mclk_run(mclk_run),
      .frame_run(frame_run), .supply_release_ok(supply_release_ok),
      .supply_trip_ok(supply_trip_ok),
      .master_clock_pin(master_clock_pin), .frame_clock(frame_clock));

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // ==========================================================
   // Shared tasks
   task automatic chk(input string what, input logic [7:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask

   task automatic wr(input logic [7:0] a, d);
      @(negedge ref_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_write = 1'b1;
      @(negedge ref_clk);
      reg_write = 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge ref_clk);
      reg_addr = a;
      @(negedge ref_clk);
      d = reg_rdata;
   endtask

   // Lock is only known by polling the flag
   task automatic poll(output logic [7:0] d);
      d = 8'h00;
      for (int i = 0; i < 400 && d[7] !== 1'b1; i++)
         rd(8'h01, d);
   endtask

   task automatic close_out;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_power_up;
      chk("reference held", 8'(reference_enable), 8'h0);
      chk("regulator held", 8'(regulator_enable), 8'h0);
      chk("core held", 8'(core_reset_out), 8'h1);
      powerdown_reset_n = 1'b1;
      cyc(5);
      chk("reference on", 8'(reference_enable), 8'h1);
      chk("regulator on", 8'(regulator_enable), 8'h1);
      wr(8'h01, 8'h05);
      chk("core early", 8'(core_reset_out), 8'h1);
      chk("write in reset", 8'(pll_ratio_out), 8'h1);
      for (int i = 0; i < 100 && core_reset_out !== 1'b0; i++)
         cyc(1);
      chk("core released", 8'(core_reset_out), 8'h0);
      chk("supply at release", 8'(supply_release_ok), 8'h1);
      cyc(60);
   endtask

   task automatic t_regs;
      wr(8'h01, 8'h93);
      chk("source", 8'(pll_source_out), 8'h1);
      chk("ratio", 8'(pll_ratio_out), 8'h3);
      rd(8'h01, rv);
      chk("lock write", rv, 8'h13);
      rd(8'h05, rv);
      chk("unmapped", rv, 8'h00);
      for (int c = 0; c < 5; c++) begin
         wr(8'h01, 8'(c));
         chk("ratio code", 8'(pll_ratio_out), 8'(c));
         chk("mclk source", 8'(pll_source_out), 8'h0);
      end
   endtask

   task automatic t_lock;
      wr(8'h01, 8'h02);
      wr(8'h00, 8'h01);
      chk("enable", 8'(pll_enable_out), 8'h1);
      rd(8'h01, rv);
      chk("no lock yet", rv, 8'h02);
      mclk_run = 1'b1;
      poll(rv);
      chk("mclk lock", rv, 8'h82);
      wr(8'h00, 8'h00);
      rd(8'h01, rv);
      chk("lock dropped", rv, 8'h02);
      mclk_run = 1'b0;
      wr(8'h01, 8'h12);
      wr(8'h00, 8'h01);
      frame_run = 1'b1;
      poll(rv);
      chk("frame lock", rv, 8'h92);
      frame_run = 1'b0;
      wr(8'h00, 8'h00);
      wr(8'h01, 8'h05);
      wr(8'h00, 8'h01);
      mclk_run = 1'b1;
      cyc(400);
      rd(8'h01, rv);
      chk("bad ratio", rv, 8'h05);
   endtask

   task automatic t_soft;
      int hi = 0;
      wr(8'h00, 8'h81);
      for (int i = 0; i < 8; i++) begin
         if (core_reset_out === 1'b1)
            hi++;
         cyc(1);
      end
      chk("soft pulse", 8'(hi), 8'h4);
      chk("enable default", 8'(pll_enable_out), 8'h0);
      chk("ratio default", 8'(pll_ratio_out), 8'h1);
      rd(8'h00, rv);
      chk("reset bit", rv, 8'h00);
      mclk_run = 1'b0;
   endtask

   task automatic t_hyst;
      wr(8'h01, 8'h14);
      powerdown_reset_n = 1'b0;
      cyc(30);
      chk("reference off", 8'(reference_enable), 8'h0);
      chk("regulator off", 8'(regulator_enable), 8'h0);
      chk("below release", 8'(supply_release_ok), 8'h0);
      chk("core kept", 8'(core_reset_out), 8'h0);
      cyc(20);
      chk("core tripped", 8'(core_reset_out), 8'h1);
      powerdown_reset_n = 1'b1;
      for (int i = 0; i < 100 && core_reset_out !== 1'b0; i++)
         cyc(1);
      chk("core back", 8'(core_reset_out), 8'h0);
      rd(8'h01, rv);
      chk("defaults back", rv, 8'h01);
   endtask

   // ==========================================================
   // Main sequence and watchdog
   initial begin
      reset = 1'b1;
      powerdown_reset_n = 1'b0;
      mclk_run = 1'b0;
      frame_run = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_write = 1'b0;
      cyc(20);
      reset = 1'b0;
      cyc(2);
      t_power_up;
      t_regs;
      t_lock;
      t_soft;
      t_hyst;
      close_out;
   end

   initial begin
      #100000;
      n_mismatch++;
      close_out;
   end
endmodule
`default_nettype wire
